// ### guest_status_control.sv
// guest status register with trap control and trap-entry state
// Function
// - 32-bit host: no width field, guest 32
// - 64-bit host: width field legal-only, may be fixed
// - host widening sets widest supported guest width
// - sret trap bit faults guest sret
// - wait trap faults guest wfi after bound
// - wait trap may fault guest wfi immediately
// - translation trap faults guest fence and satp
// - six-bit selector holds zero to source count
// - selector zero selects none; may hardwire
// - user bit gates guest memory instructions
// - trap to hypervisor records virtualization mode
// - sret in host supervisor restores virtualization mode
// - guest trap records privilege; else unchanged
// - previous privilege drives guest memory access
// - guest-address flag follows trap value kind
// - endian bit sets guest load/store order
// - endian bit sets guest page-table order
// - endian bit legal-only, may be hardwired
// - virtualization flag marks guest execution
`default_nettype none
module guest_status_control #(
  parameter int         HOST_64     = 1,
  parameter int         WIDTH_FIXED = 0,
  parameter int         IRQ_COUNT   = 8,
  parameter int         BE_FIXED    = 0,
  parameter int         WFI_ALWAYS  = 0,
  parameter logic [1:0] HOST_PRIV_S = guest_status_pkg::PRIV_S
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire guest_status_pkg::csr_req_s  csrReq,
  input  wire guest_status_pkg::trap_s     trapIn,
  input  wire logic                        hostWiden,
  input  wire logic                        hostBigEndian,
  input  wire logic [1:0]                  curPriv,
  input  wire logic                        machineWaitTrap,
  input  wire logic                        execSret,
  input  wire logic                        execWfi,
  input  wire logic                        wfiDone,
  input  wire logic                        execXlatOp,
  input  wire logic                        execGuestMem,
  input  wire logic                        execHypInstr,
  output logic [63:0]                      csrRdata,
  output logic                             virtMode,
  output logic                             virtInstrFault,
  output logic                             illegalInstrFault,
  output logic [1:0]                       guestMemPriv,
  output logic                             guestBigEndian,
  output logic                             guestPtBigEndian,
  output logic [5:0]                       guestExtIrqSel,
  output logic [1:0]                       guestWordWidth
);
  logic [1:0] guestWidthField;
  logic       trapGuestSret;
  logic       trapGuestWait;
  logic       trapGuestXlat;
  logic [5:0] guestExtIrqSelect;
  logic       hypInUserEnable;
  logic       prevGuestPrivilege;
  logic       prevVirtualization;
  logic       guestAddrFlag;
  logic       guestBigEndianBit;
  logic       wfiExpired;
  logic       inGuestSup;
  logic       inHostUser;
  logic [1:0] next_width;
  logic [5:0] next_sel;
  logic [63:0] readValue;

  function automatic logic [1:0] legal_width(input logic [1:0] req, input logic [1:0] cur);
    if (HOST_64 == 0) begin
      legal_width = guest_status_pkg::WIDTH_32;
    end else if (WIDTH_FIXED != 0) begin
      legal_width = guest_status_pkg::WIDTH_64;
    end else if (req == guest_status_pkg::WIDTH_32 || req == guest_status_pkg::WIDTH_64) begin
      legal_width = req;
    end else begin
      legal_width = cur;
    end
  endfunction

  assign inGuestSup = virtMode && (curPriv == guest_status_pkg::PRIV_S);
  assign inHostUser = !virtMode && (curPriv == guest_status_pkg::PRIV_U);
  assign next_width = legal_width(csrReq.wdata[guest_status_pkg::WIDTH_LSB +: guest_status_pkg::WIDTH_W],
                                  guestWidthField);
  assign next_sel   = (IRQ_COUNT == 0) ? 6'h00 :
                      csrReq.wdata[guest_status_pkg::SEL_LSB +: guest_status_pkg::SEL_W];

  wfi_timer #(
    .LIMIT (guest_status_pkg::WFI_LIMIT)
  ) u_wfi_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .waiting  (execWfi && inGuestSup && !wfiDone),
    .expired  (wfiExpired)
  );

  // width field
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      guestWidthField <= (HOST_64 != 0) ? guest_status_pkg::WIDTH_64 : guest_status_pkg::WIDTH_32;
    end else if (HOST_64 == 0) begin
      guestWidthField <= guest_status_pkg::WIDTH_32;
    end else if (hostWiden && WIDTH_FIXED == 0) begin
      guestWidthField <= guest_status_pkg::WIDTH_64;
    end else if (csrReq.valid && csrReq.write) begin
      guestWidthField <= next_width;
    end
  end

  // software-written control bits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trapGuestSret     <= 1'b0;
      trapGuestWait     <= 1'b0;
      trapGuestXlat     <= 1'b0;
      guestExtIrqSelect <= 6'h00;
      hypInUserEnable   <= 1'b0;
    end else if (csrReq.valid && csrReq.write) begin
      trapGuestSret     <= csrReq.wdata[guest_status_pkg::BIT_TRAP_SRET];
      trapGuestWait     <= csrReq.wdata[guest_status_pkg::BIT_TRAP_WAIT];
      trapGuestXlat     <= csrReq.wdata[guest_status_pkg::BIT_TRAP_XLAT];
      if (next_sel <= IRQ_COUNT[5:0]) begin
        guestExtIrqSelect <= next_sel;
      end
      hypInUserEnable   <= csrReq.wdata[guest_status_pkg::BIT_HYP_USER];
    end
  end

  // endian bit; a fixed setting follows the host order at all times, not only on writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      guestBigEndianBit <= 1'b0;
    end else if (BE_FIXED != 0) begin
      guestBigEndianBit <= hostBigEndian;
    end else if (csrReq.valid && csrReq.write) begin
      guestBigEndianBit <= csrReq.wdata[guest_status_pkg::BIT_GUEST_BE];
    end
  end

  // trap entry state; hardware update wins over a same-cycle write
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prevVirtualization <= 1'b0;
      prevGuestPrivilege <= 1'b0;
      guestAddrFlag      <= 1'b0;
    end else if (trapIn.take && trapIn.toHyp) begin
      prevVirtualization <= trapIn.virt;
      if (trapIn.virt) begin
        prevGuestPrivilege <= trapIn.priv[0];
      end
      guestAddrFlag      <= trapIn.guestAddr;
    end else if (csrReq.valid && csrReq.write) begin
      prevVirtualization <= csrReq.wdata[guest_status_pkg::BIT_PREV_VIRT];
      prevGuestPrivilege <= csrReq.wdata[guest_status_pkg::BIT_PREV_PRIV];
      guestAddrFlag      <= csrReq.wdata[guest_status_pkg::BIT_GUEST_ADDR];
    end
  end

  // virtualization mode
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      virtMode <= 1'b0;
    end else if (trapIn.take) begin
      virtMode <= 1'b0;
    end else if (execSret && !virtMode && curPriv == HOST_PRIV_S) begin
      virtMode <= prevVirtualization;
    end
  end

  // instruction faults
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      virtInstrFault    <= 1'b0;
      illegalInstrFault <= 1'b0;
    end else begin
      virtInstrFault <= (inGuestSup && execSret && trapGuestSret)
        || (inGuestSup && execXlatOp && trapGuestXlat)
        || (trapGuestWait && !machineWaitTrap && (wfiExpired
        || (WFI_ALWAYS != 0 && execWfi && inGuestSup)));
      illegalInstrFault <= inHostUser && execHypInstr && !(hypInUserEnable && execGuestMem);
    end
  end

  always_comb begin
    readValue = 64'h0;
    if (HOST_64 != 0) begin
      readValue[guest_status_pkg::WIDTH_LSB +: guest_status_pkg::WIDTH_W] = guestWidthField;
    end
    readValue[guest_status_pkg::BIT_TRAP_SRET] = trapGuestSret;
    readValue[guest_status_pkg::BIT_TRAP_WAIT] = trapGuestWait;
    readValue[guest_status_pkg::BIT_TRAP_XLAT] = trapGuestXlat;
    readValue[guest_status_pkg::SEL_LSB +: guest_status_pkg::SEL_W] = guestExtIrqSelect;
    readValue[guest_status_pkg::BIT_HYP_USER]  = hypInUserEnable;
    readValue[guest_status_pkg::BIT_PREV_PRIV] = prevGuestPrivilege;
    readValue[guest_status_pkg::BIT_PREV_VIRT] = prevVirtualization;
    readValue[guest_status_pkg::BIT_GUEST_ADDR] = guestAddrFlag;
    readValue[guest_status_pkg::BIT_GUEST_BE]  = guestBigEndianBit;
  end

  // registered views
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      csrRdata         <= 64'h0;
      guestMemPriv     <= 2'h0;
      guestBigEndian   <= 1'b0;
      guestPtBigEndian <= 1'b0;
      guestExtIrqSel   <= 6'h00;
      guestWordWidth   <= 2'h0;
    end else begin
      csrRdata         <= readValue;
      guestMemPriv     <= {1'b0, prevGuestPrivilege};
      guestBigEndian   <= guestBigEndianBit;
      guestPtBigEndian <= guestBigEndianBit;
      guestExtIrqSel   <= guestExtIrqSelect;
      guestWordWidth   <= guestWidthField;
    end
  end

  property p_sret_fault;
    @(posedge core_clk) disable iff (reset)
      (inGuestSup && execSret && trapGuestSret) |=> virtInstrFault;
  endproperty
  a_sret_fault: assert property (p_sret_fault) else $error("guest sret not faulted");

  property p_xlat_fault;
    @(posedge core_clk) disable iff (reset)
      (inGuestSup && execXlatOp && trapGuestXlat) |=> virtInstrFault;
  endproperty
  a_xlat_fault: assert property (p_xlat_fault) else $error("guest translation op not faulted");

  property p_wfi_bound;
    @(posedge core_clk) disable iff (reset)
      (execWfi && inGuestSup && !wfiDone && trapGuestWait && !machineWaitTrap)[*8]
      ##1 (execWfi && inGuestSup && !wfiDone && trapGuestWait && !machineWaitTrap)[*8]
      ##1 (execWfi && inGuestSup && !wfiDone && trapGuestWait && !machineWaitTrap) |=> virtInstrFault;
  endproperty
  a_wfi_bound: assert property (p_wfi_bound) else $error("guest wfi exceeded bound");

  property p_prev_virt;
    @(posedge core_clk) disable iff (reset)
      (trapIn.take && trapIn.toHyp) |=> prevVirtualization == $past(trapIn.virt);
  endproperty
  a_prev_virt: assert property (p_prev_virt) else $error("previous virtualization wrong");

  property p_prev_priv_hold;
    @(posedge core_clk) disable iff (reset)
      (trapIn.take && trapIn.toHyp && !trapIn.virt) |=> $stable(prevGuestPrivilege);
  endproperty
  a_prev_priv_hold: assert property (p_prev_priv_hold) else $error("previous privilege changed");

  property p_gaddr;
    @(posedge core_clk) disable iff (reset)
      (trapIn.take && trapIn.toHyp) |=> guestAddrFlag == $past(trapIn.guestAddr);
  endproperty
  a_gaddr: assert property (p_gaddr) else $error("guest address flag wrong");

  property p_sret_virt;
    @(posedge core_clk) disable iff (reset)
      (execSret && !virtMode && curPriv == HOST_PRIV_S && !trapIn.take) |=> virtMode == $past(prevVirtualization);
  endproperty
  a_sret_virt: assert property (p_sret_virt) else $error("sret did not restore mode");

  property p_sel_range;
    @(posedge core_clk) disable iff (reset)
      guestExtIrqSelect <= IRQ_COUNT[5:0];
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("selector out of range");

  property p_user_gate;
    @(posedge core_clk) disable iff (reset)
      (inHostUser && execHypInstr && !hypInUserEnable) |=> illegalInstrFault;
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("user hypervisor instr not illegal");

  property p_endian;
    @(posedge core_clk) disable iff (reset)
      ##1 (guestBigEndian == $past(guestBigEndianBit)) && (guestPtBigEndian == guestBigEndian);
  endproperty
  a_endian: assert property (p_endian) else $error("endian view mismatch");

  property p_prev_priv_take;
    @(posedge core_clk) disable iff (reset)
      (trapIn.take && trapIn.toHyp && trapIn.virt) |=> prevGuestPrivilege == $past(trapIn.priv[0]);
  endproperty
  a_prev_priv_take: assert property (p_prev_priv_take) else $error("previous privilege not captured");

  property p_user_allow;
    @(posedge core_clk) disable iff (reset)
      (inHostUser && execHypInstr && execGuestMem && hypInUserEnable) |=> !illegalInstrFault;
  endproperty
  a_user_allow: assert property (p_user_allow) else $error("allowed guest memory instr faulted");

  property p_trap_leaves_guest;
    @(posedge core_clk) disable iff (reset)
      trapIn.take |=> !virtMode;
  endproperty
  a_trap_leaves_guest: assert property (p_trap_leaves_guest) else $error("trap left guest mode set");

  property p_width_legal;
    @(posedge core_clk) disable iff (reset)
      (guestWidthField == guest_status_pkg::WIDTH_32) || (guestWidthField == guest_status_pkg::WIDTH_64);
  endproperty
  a_width_legal: assert property (p_width_legal) else $error("width code not legal");

  c_trap_guest: cover property (@(posedge core_clk) disable iff (reset) trapIn.take && trapIn.virt);
  c_sret_enter: cover property (@(posedge core_clk) disable iff (reset) !virtMode ##1 virtMode);
  c_wfi_expire: cover property (@(posedge core_clk) disable iff (reset) wfiExpired);
  c_user_gate: cover property (@(posedge core_clk) disable iff (reset) inHostUser && execHypInstr && !hypInUserEnable);
  c_widen: cover property (@(posedge core_clk) disable iff (reset) hostWiden);
endmodule // guest_status_control
`default_nettype wire

// ### guest_status_pkg.sv
// package: field layout, encodings and carriers for the guest status register
`default_nettype none
package guest_status_pkg;
  localparam int REG_W            = 64;
  localparam int BIT_GUEST_BE     = 5;
  localparam int BIT_GUEST_ADDR   = 6;
  localparam int BIT_PREV_VIRT    = 7;
  localparam int BIT_PREV_PRIV    = 8;
  localparam int BIT_HYP_USER     = 9;
  localparam int SEL_LSB          = 12;
  localparam int SEL_W            = 6;
  localparam int BIT_TRAP_XLAT    = 20;
  localparam int BIT_TRAP_WAIT    = 21;
  localparam int BIT_TRAP_SRET    = 22;
  localparam int WIDTH_LSB        = 32;
  localparam int WIDTH_W          = 2;
  localparam logic [1:0] WIDTH_32 = 2'h1;
  localparam logic [1:0] WIDTH_64 = 2'h2;
  localparam logic [1:0] PRIV_U   = 2'h0;
  localparam logic [1:0] PRIV_S   = 2'h1;
  localparam logic [1:0] PRIV_M   = 2'h3;
  localparam int WFI_LIMIT        = 16;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [63:0] wdata;
  } csr_req_s;

  typedef struct packed {
    logic       take;
    logic       toHyp;
    logic       virt;
    logic [1:0] priv;
    logic       guestAddr;
  } trap_s;
endpackage
`default_nettype wire

// ### testbench.sv
// self-checking testbench for the guest status register block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IRQ = 8;
  logic                       core_clk;
  logic                       reset;
  guest_status_pkg::csr_req_s csrReq;
  guest_status_pkg::trap_s    trapIn;
  logic                       hostWiden;
  logic                       hostBigEndian;
  logic [1:0]                 curPriv;
  logic                       machineWaitTrap;
  logic [4:0]                 execVec;
  logic                       wfiDone;
  logic [63:0]                csrRdata;
  logic                       virtMode;
  logic                       virtInstrFault;
  logic                       illegalInstrFault;
  logic [1:0]                 guestMemPriv;
  logic                       guestBigEndian;
  logic                       guestPtBigEndian;
  logic [5:0]                 guestExtIrqSel;
  logic [1:0]                 guestWordWidth;
  logic [63:0]                model;
  int                         mismatches;
  int                         n_compared;
  int                         cycles = 0;
  int                         k;

  guest_status_control #(.HOST_64(1), .WIDTH_FIXED(0), .IRQ_COUNT(IRQ), .BE_FIXED(0), .WFI_ALWAYS(0)) dut_u (
    .core_clk(core_clk), .reset(reset), .csrReq(csrReq), .trapIn(trapIn), .hostWiden(hostWiden),
    .hostBigEndian(hostBigEndian), .curPriv(curPriv), .machineWaitTrap(machineWaitTrap),
    .execSret(execVec[4]), .execWfi(execVec[3]), .wfiDone(wfiDone), .execXlatOp(execVec[2]),
    .execGuestMem(execVec[1]), .execHypInstr(execVec[0]), .csrRdata(csrRdata), .virtMode(virtMode),
    .virtInstrFault(virtInstrFault), .illegalInstrFault(illegalInstrFault), .guestMemPriv(guestMemPriv),
    .guestBigEndian(guestBigEndian), .guestPtBigEndian(guestPtBigEndian),
    .guestExtIrqSel(guestExtIrqSel), .guestWordWidth(guestWordWidth));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // expected register image after a software write
  function automatic logic [63:0] next_model(input logic [63:0] old, input logic [63:0] d);
    logic [63:0] m;
    m = old;
    m[22:20] = d[22:20];
    m[9:5] = d[9:5];
    if (d[17:12] <= 6'(IRQ)) m[17:12] = d[17:12];
    if (d[33:32] == 2'h1 || d[33:32] == 2'h2) m[33:32] = d[33:32];
    return m;
  endfunction

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at time %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_all();
    chk(csrRdata, model);
    chk(64'(guestExtIrqSel), 64'(model[17:12]));
    chk(64'(guestWordWidth), 64'(model[33:32]));
    chk(64'({guestBigEndian, guestPtBigEndian}), {62'h0, model[5], model[5]});
    chk(64'(guestMemPriv), {62'h0, 1'b0, model[8]});
  endtask

  task automatic csr_wr(input logic [63:0] d);
    @(posedge core_clk);
    csrReq <= '{valid: 1'b1, write: 1'b1, wdata: d};
    @(posedge core_clk);
    csrReq <= '0;
    model = next_model(model, d);
    @(posedge core_clk);
    #1;
    chk_all();
  endtask

  task automatic trap(input logic v, input logic [1:0] p, input logic ga);
    @(posedge core_clk);
    trapIn <= '{take: 1'b1, toHyp: 1'b1, virt: v, priv: p, guestAddr: ga};
    @(posedge core_clk);
    trapIn <= '0;
    model[7] = v;
    if (v) model[8] = p[0];
    model[6] = ga;
    @(posedge core_clk);
    #1;
    chk_all();
    chk(64'(virtMode), 64'h0);
  endtask

  // present one instruction for a cycle and look at the faults it raises
  task automatic pulse(input logic [4:0] ex, input logic expV, input logic expI);
    @(posedge core_clk);
    execVec <= ex;
    @(posedge core_clk);
    execVec <= '0;
    #1;
    chk(64'(virtInstrFault), 64'(expV));
    chk(64'(illegalInstrFault), 64'(expI));
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    reset = 1'b1;
    csrReq = '0;
    trapIn = '0;
    hostWiden = 1'b0;
    hostBigEndian = 1'b0;
    curPriv = guest_status_pkg::PRIV_S;
    machineWaitTrap = 1'b0;
    execVec = '0;
    wfiDone = 1'b0;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(67));
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    model = 64'h0000_0002_0000_0000;
    repeat (2) @(posedge core_clk);
    #1;
    chk_all();
    for (int i = 0; i < 30; i++) begin
      case (i)
        0: csr_wr(64'h0000_0001_0000_8000);
        1: csr_wr(64'h0000_0003_0000_9000);
        2: csr_wr(64'h0000_0000_0003_F020);
        3: csr_wr(64'hFFFF_FFFF_FFFF_FFFF);
        4: csr_wr(64'h0000_0002_0000_0000);
        default: csr_wr({$urandom, $urandom});
      endcase
    end
    csr_wr(64'h0000_0001_0000_0000);
    @(posedge core_clk);
    hostWiden <= 1'b1;
    @(posedge core_clk);
    hostWiden <= 1'b0;
    model[33:32] = guest_status_pkg::WIDTH_64;
    @(posedge core_clk);
    #1;
    chk_all();
    trap(1'b1, guest_status_pkg::PRIV_S, 1'b1);
    trap(1'b0, guest_status_pkg::PRIV_U, 1'b0);
    csr_wr(model & 64'hFFFF_FFFF_FF8F_FFFF);
    trap(1'b1, guest_status_pkg::PRIV_U, 1'b0);
    pulse(5'b10000, 1'b0, 1'b0);
    chk(64'(virtMode), 64'h1);
    pulse(5'b10000, 1'b0, 1'b0);
    pulse(5'b00100, 1'b0, 1'b0);
    csr_wr(model | 64'h0000_0000_0070_0000);
    pulse(5'b10000, 1'b1, 1'b0);
    pulse(5'b00100, 1'b1, 1'b0);
    @(posedge core_clk);
    execVec <= 5'b01000;
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (k < 40 && virtInstrFault !== 1'b1);
    chk(64'(k >= guest_status_pkg::WFI_LIMIT && k <= guest_status_pkg::WFI_LIMIT + 2), 64'h1);
    @(posedge core_clk);
    wfiDone <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    chk(64'(virtInstrFault), 64'h0);
    @(posedge core_clk);
    execVec <= '0;
    wfiDone <= 1'b0;
    trap(1'b0, guest_status_pkg::PRIV_S, 1'b0);
    @(posedge core_clk);
    curPriv <= guest_status_pkg::PRIV_U;
    csr_wr(model & ~64'h200);
    pulse(5'b00011, 1'b0, 1'b1);
    pulse(5'b00001, 1'b0, 1'b1);
    csr_wr(model | 64'h200);
    pulse(5'b00011, 1'b0, 1'b0);
    pulse(5'b00001, 1'b0, 1'b1);
    finish_test();
  end
endmodule // testbench
`default_nettype wire

// ### wfi_timer.sv
// wait-instruction time limit counter for guest mode
`default_nettype none
module wfi_timer #(
  parameter int LIMIT = guest_status_pkg::WFI_LIMIT
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic waiting,
  output logic      expired
);
  logic [$clog2(LIMIT+1)-1:0] count;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (!waiting) begin
      count <= '0;
    end else if (count != LIMIT[$clog2(LIMIT+1)-1:0]) begin
      count <= count + 1'b1;
    end
  end

  assign expired = waiting && (count == LIMIT[$clog2(LIMIT+1)-1:0]);
endmodule // wfi_timer
`default_nettype wire
